// >>> core/i2m_consts.svh
/*
 * Constants of the I2C master port: register byte offsets, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from files that need these numbers.
 */
`ifndef I2M_CONSTS_SVH
`define I2M_CONSTS_SVH

// register byte offsets on the bus
`define I2M_OFS_BUF     8'h00
`define I2M_OFS_RELOAD  8'h04
`define I2M_OFS_CTRL    8'h08
`define I2M_OFS_CTRL2   8'h0c
`define I2M_OFS_STAT    8'h10
`define I2M_OFS_FLAGS   8'h14

// port_ctrl_reg fields
`define I2M_CTRL_WRITE_COLLISION_FLAG   7
`define I2M_CTRL_EN     5
`define I2M_MODE_LSB    0
`define I2M_MODE_MASTER 4'h8

// port_ctrl2_reg fields
`define I2M_C2_ACK_RECEIVED_FLAG  6
`define I2M_C2_ACKDT    5
`define I2M_C2_ACKEN    4
`define I2M_C2_RCEN     3
`define I2M_C2_STOP     2
`define I2M_C2_RESTART  1
`define I2M_C2_START    0

// port_status_reg and flag register fields
`define I2M_ST_STOP     4
`define I2M_ST_START    3
`define I2M_ST_BF       0
`define I2M_FL_IRQ      0
`define I2M_FL_BCL      1

// reset values
`define I2M_RST_BYTE    8'h00
`define I2M_RST_RELOAD  7'h00
`define I2M_RST_MODE    4'h0

// bit counts of one byte slot (index of last bit)
`define I2M_DATA_LAST   4'h7
`define I2M_TX_LAST     4'h8

// generator step: two steps per 200 ns instruction cycle
`define I2M_MCLK_NS     50
`define I2M_TICK_NS     100
`define I2M_TICK_CYC    (`I2M_TICK_NS / `I2M_MCLK_NS)

`endif

// >>> core/i2m_master.sv
/*
 * I2C master port: classic Wishbone register slave, START, Repeated START,
 * byte, acknowledge and STOP sequencing, bus-collision and write-collision
 * checks, bus START/STOP detection.
 * Assumes open-drain pads outside (oe high pulls low), one clock mclk.
 */
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_master
	import i2m_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	i2m_state_t  state;
	i2m_kind_t   kind;
	i2m_lines_t  line_s;
	i2m_lines_t  line_q;
	logic [1:0]  sync_q;
	logic [7:0]  xfer_buffer;
	logic [7:0]  shift_reg;
	logic [6:0]  addr_reload_reg;
	logic [3:0]  port_mode_select;
	logic [3:0]  bit_idx;
	logic [3:0]  tick_cnt;
	logic [7:0]  ofs;
	logic        port_enable;
	logic        write_collision_flag;
	logic        ack_received_flag;
	logic        ackdt;
	logic        acken;
	logic        rcen;
	logic        stop_go;
	logic        restart_go;
	logic        start_go;
	logic        start_seen;
	logic        stop_seen;
	logic        buf_full;
	logic        tx_pend;
	logic        port_irq_flag;
	logic        bus_collision_flag;
	logic        scl_drv;
	logic        sda_drv;
	logic        tick;
	logic        gen_load;
	logic        gen_to;
	logic        seq_done;
	logic        ev_irq;
	logic        ev_bcl;
	logic        rx_load;
	logic        ack_upd;
	logic        ack_val;
	logic        bf_clr;
	logic        master_on;
	logic        busy;
	logic        wr;
	logic        rd;
	logic        coll;
	logic        sends;
	logic        drive_bit;
	logic        last_bit;
	logic        start_evt;
	logic        stop_evt;

	// pins pass two flops before any logic looks at them
	i2m_sync #(.W(2)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({scl_i, sda_i}),
		.q    (sync_q)
	);
	assign line_s = sync_q;

	// open drain: the pad only ever pulls low
	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = scl_drv;
	assign sda_oe = sda_drv;

	// bus decode; a write takes effect on the edge that sees ack
	assign ofs = {wb_adr_i[7:2], 2'b00};
	assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o;

	assign master_on = port_enable & (port_mode_select == `I2M_MODE_MASTER);
	assign busy      = (state != i2m_idle) | start_go | restart_go | stop_go | rcen | acken | tx_pend;

	// one-cycle ack, dropped in the cycle after it was given
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// read data registered together with ack; unmapped reads give zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			case (ofs)
				`I2M_OFS_BUF:    wb_dat_o <= {24'h000000, xfer_buffer};
				`I2M_OFS_RELOAD: wb_dat_o <= {25'h0, addr_reload_reg};
				`I2M_OFS_CTRL:   wb_dat_o <= {24'h000000, write_collision_flag, 1'b0, port_enable, 1'b0,
					port_mode_select};
				`I2M_OFS_CTRL2:  wb_dat_o <= {24'h000000, 1'b0, ack_received_flag, ackdt, acken, rcen,
					stop_go, restart_go, start_go};
				`I2M_OFS_STAT:   wb_dat_o <= {24'h000000, 3'h0, stop_seen, start_seen, 2'h0, buf_full};
				`I2M_OFS_FLAGS:  wb_dat_o <= {30'h0, bus_collision_flag, port_irq_flag};
				default:         wb_dat_o <= '0;
			endcase
		end
	end

	// step enable: two generator steps per instruction cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 4'h0;
			tick     <= 1'b0;
		end else if (tick_cnt == 4'(`I2M_TICK_CYC - 1)) begin
			tick_cnt <= 4'h0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 4'h1;
			tick     <= 1'b0;
		end
	end

	i2m_rate_gen #(.W(7)) u_gen (
		.mclk    (mclk),
		.rst     (rst),
		.tick    (tick),
		.load    (gen_load),
		.halt    (state == i2m_idle),
		.reload  (addr_reload_reg),
		.timeout (gen_to)
	);

	// mode, enable and reload value
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_enable      <= 1'b0;
			port_mode_select <= `I2M_RST_MODE;
			addr_reload_reg  <= `I2M_RST_RELOAD;
		end else if (wr && ofs == `I2M_OFS_CTRL) begin
			port_enable      <= wb_dat_i[`I2M_CTRL_EN];
			port_mode_select <= wb_dat_i[`I2M_MODE_LSB +: 4];
		end else if (wr && ofs == `I2M_OFS_RELOAD) begin
			addr_reload_reg  <= wb_dat_i[6:0];
		end
	end

	// transfer buffer, full flag and write collision; no queueing of events
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			xfer_buffer          <= `I2M_RST_BYTE;
			buf_full             <= 1'b0;
			tx_pend              <= 1'b0;
			write_collision_flag <= 1'b0;
		end else begin
			if (wr && ofs == `I2M_OFS_BUF && busy) begin
				write_collision_flag <= 1'b1;
			end else if (wr && ofs == `I2M_OFS_CTRL && !wb_dat_i[`I2M_CTRL_WRITE_COLLISION_FLAG]) begin
				write_collision_flag <= 1'b0;
			end
			if (seq_done || !master_on) begin
				tx_pend <= 1'b0;
			end
			if (rx_load) begin
				xfer_buffer <= shift_reg;
				buf_full    <= 1'b1;
			end else if (wr && ofs == `I2M_OFS_BUF && !busy) begin
				xfer_buffer <= wb_dat_i[7:0];
				buf_full    <= 1'b1;
				tx_pend     <= master_on;
			end else if (bf_clr || (rd && ofs == `I2M_OFS_BUF)) begin
				buf_full <= 1'b0;
			end
		end
	end

	// second control register; sequence bits self-clear when done
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_received_flag <= 1'b0;
			ackdt             <= 1'b0;
			acken             <= 1'b0;
			rcen              <= 1'b0;
			stop_go           <= 1'b0;
			restart_go        <= 1'b0;
			start_go          <= 1'b0;
		end else begin
			if (ack_upd) begin
				ack_received_flag <= ack_val;
			end
			if (wr && ofs == `I2M_OFS_CTRL2) begin
				ackdt <= wb_dat_i[`I2M_C2_ACKDT];
				if (!busy) begin
					acken      <= wb_dat_i[`I2M_C2_ACKEN];
					rcen       <= wb_dat_i[`I2M_C2_RCEN];
					stop_go    <= wb_dat_i[`I2M_C2_STOP];
					restart_go <= wb_dat_i[`I2M_C2_RESTART];
					start_go   <= wb_dat_i[`I2M_C2_START];
				end
			end
			if (seq_done || !master_on) begin
				acken      <= 1'b0;
				rcen       <= 1'b0;
				stop_go    <= 1'b0;
				restart_go <= 1'b0;
				start_go   <= 1'b0;
			end
		end
	end

	// bus condition detection on the synchronised lines
	assign start_evt = line_q.sda & ~line_s.sda & line_q.scl & line_s.scl;
	assign stop_evt  = ~line_q.sda & line_s.sda & line_q.scl & line_s.scl;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			line_q <= '1;
		end else begin
			line_q <= line_s;
		end
	end

	// start-seen and stop-seen, cleared while the port is off
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else if (!port_enable) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else if (start_evt) begin
			start_seen <= 1'b1;
			stop_seen  <= 1'b0;
		end else if (stop_evt) begin
			stop_seen  <= 1'b1;
			start_seen <= 1'b0;
		end
	end

	// sticky flags; software clears by writing ones, a same-cycle set wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_irq_flag      <= 1'b0;
			bus_collision_flag <= 1'b0;
		end else begin
			if (wr && ofs == `I2M_OFS_FLAGS) begin
				if (wb_dat_i[`I2M_FL_IRQ]) port_irq_flag <= 1'b0;
				if (wb_dat_i[`I2M_FL_BCL]) bus_collision_flag <= 1'b0;
			end
			if (ev_irq || (master_on && stop_evt)) begin
				port_irq_flag <= 1'b1;
			end
			if (ev_bcl) begin
				bus_collision_flag <= 1'b1;
			end
		end
	end

	// level pulled onto data for the current bit slot (1 = pull low)
	always_comb begin
		case (kind)
			i2m_bk_tx:  drive_bit = (bit_idx < `I2M_TX_LAST) & ~shift_reg[7];
			i2m_bk_ack: drive_bit = ~ackdt;
			default:    drive_bit = 1'b0;
		endcase
	end

	assign sends    = ((kind == i2m_bk_tx) & (bit_idx < `I2M_TX_LAST)) | (kind == i2m_bk_ack);
	assign last_bit = (kind == i2m_bk_ack) |
		((kind == i2m_bk_tx) & (bit_idx == `I2M_TX_LAST)) |
		((kind == i2m_bk_rx) & (bit_idx == `I2M_DATA_LAST));

	// arbitration check: a released line sensed low means another master
	always_comb begin
		case (state)
			i2m_idle:    coll = master_on & ~seq_done & start_go & ~line_s.scl & ~line_s.sda;
			i2m_s_wait:  coll = ~line_s.scl | (gen_to & ~line_s.sda);
			i2m_r_sdahi: coll = gen_to & ~line_s.sda;
			i2m_r_rise:  coll = line_s.scl & ~line_s.sda;
			i2m_r_high:  coll = ~line_s.scl | ~line_s.sda;
			i2m_b_rise:  coll = sends & ~sda_drv & line_s.scl & ~line_s.sda;
			i2m_b_high:  coll = sends & ~sda_drv & ~line_s.sda;
			default:     coll = 1'b0;
		endcase
	end

	// sequencer; the seq_done guard stops a just-finished bit relaunching
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state     <= i2m_idle;
			kind      <= i2m_bk_tx;
			bit_idx   <= 4'h0;
			shift_reg <= `I2M_RST_BYTE;
			scl_drv   <= 1'b0;
			sda_drv   <= 1'b0;
			gen_load  <= 1'b0;
			seq_done  <= 1'b0;
			ev_irq    <= 1'b0;
			ev_bcl    <= 1'b0;
			rx_load   <= 1'b0;
			ack_upd   <= 1'b0;
			ack_val   <= 1'b0;
			bf_clr    <= 1'b0;
		end else begin
			gen_load <= 1'b0;
			seq_done <= 1'b0;
			ev_irq   <= 1'b0;
			ev_bcl   <= 1'b0;
			rx_load  <= 1'b0;
			ack_upd  <= 1'b0;
			bf_clr   <= 1'b0;
			if (!master_on) begin
				state   <= i2m_idle;
				scl_drv <= 1'b0;
				sda_drv <= 1'b0;
			end else if (coll) begin
				ev_bcl   <= 1'b1;
				seq_done <= 1'b1;
				scl_drv  <= 1'b0;
				sda_drv  <= 1'b0;
				state    <= i2m_idle;
			end else begin
				case (state)
					i2m_idle: begin
						if (seq_done) begin
							state <= i2m_idle;
						end else if (start_go) begin
							if (line_s.scl && line_s.sda) begin
								gen_load <= 1'b1;
								state    <= i2m_s_wait;
							end
						end else if (restart_go) begin
							scl_drv <= 1'b1;
							state   <= i2m_r_scllo;
						end else if (stop_go) begin
							sda_drv <= 1'b1;
							state   <= i2m_p_low;
						end else if (tx_pend || rcen || acken) begin
							kind      <= tx_pend ? i2m_bk_tx : (rcen ? i2m_bk_rx : i2m_bk_ack);
							shift_reg <= xfer_buffer;
							bit_idx   <= 4'h0;
							scl_drv   <= 1'b1;
							gen_load  <= 1'b1;
							state     <= i2m_b_low;
						end
					end
					i2m_s_wait: if (gen_to) begin
						sda_drv  <= 1'b1;
						gen_load <= 1'b1;
						state    <= i2m_s_hold;
					end
					i2m_s_hold: if (gen_to) begin
						seq_done <= 1'b1;
						ev_irq   <= 1'b1;
						state    <= i2m_idle;
					end
					i2m_r_scllo: if (!line_s.scl) begin
						sda_drv  <= 1'b0;
						gen_load <= 1'b1;
						state    <= i2m_r_sdahi;
					end
					i2m_r_sdahi: if (gen_to) begin
						scl_drv <= 1'b0;
						state   <= i2m_r_rise;
					end
					i2m_r_rise: if (line_s.scl) begin
						gen_load <= 1'b1;
						state    <= i2m_r_high;
					end
					i2m_r_high: if (gen_to) begin
						sda_drv  <= 1'b1;
						gen_load <= 1'b1;
						state    <= i2m_r_sdalo;
					end
					i2m_r_sdalo: if (gen_to) begin
						seq_done <= 1'b1;
						ev_irq   <= 1'b1;
						state    <= i2m_idle;
					end
					i2m_b_low: begin
						// data changes only once the clock is seen low
						if (!line_s.scl) begin
							sda_drv <= drive_bit;
						end
						if (gen_to) begin
							scl_drv <= 1'b0;
							state   <= i2m_b_rise;
						end
					end
					i2m_b_rise: if (line_s.scl) begin
						gen_load <= 1'b1;
						state    <= i2m_b_high;
					end
					i2m_b_high: if (gen_to) begin
						shift_reg <= {shift_reg[6:0], line_s.sda};
						scl_drv   <= 1'b1;
						bf_clr    <= (kind == i2m_bk_tx) && (bit_idx == `I2M_DATA_LAST);
						if (last_bit) begin
							ack_upd  <= (kind == i2m_bk_tx);
							ack_val  <= line_s.sda;
							rx_load  <= (kind == i2m_bk_rx);
							seq_done <= 1'b1;
							ev_irq   <= 1'b1;
							state    <= i2m_idle;
						end else begin
							bit_idx  <= bit_idx + 4'h1;
							gen_load <= 1'b1;
							state    <= i2m_b_low;
						end
					end
					i2m_p_low: if (!line_s.sda) begin
						gen_load <= 1'b1;
						state    <= i2m_p_scl;
					end
					i2m_p_scl: if (gen_to) begin
						scl_drv <= 1'b0;
						state   <= i2m_p_rise;
					end
					i2m_p_rise: if (line_s.scl) begin
						gen_load <= 1'b1;
						state    <= i2m_p_sda;
					end
					i2m_p_sda: if (gen_to) begin
						sda_drv  <= 1'b0;
						gen_load <= 1'b1;
						state    <= i2m_p_end;
					end
					i2m_p_end: if (gen_to) begin
						seq_done <= 1'b1;
						ev_irq   <= 1'b1;
						state    <= i2m_idle;
					end
					default: state <= i2m_idle;
				endcase
			end
		end
	end
endmodule : i2m_master

// >>> core/i2m_pkg.sv
/*
 * Types of the I2C master port: sequencer states, bit-slot kinds and the
 * sampled bus line pair.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2m_pkg;

	// sequencer states
	typedef enum logic [4:0] {
		i2m_idle,
		i2m_s_wait,
		i2m_s_hold,
		i2m_r_scllo,
		i2m_r_sdahi,
		i2m_r_rise,
		i2m_r_high,
		i2m_r_sdalo,
		i2m_b_low,
		i2m_b_rise,
		i2m_b_high,
		i2m_p_low,
		i2m_p_scl,
		i2m_p_rise,
		i2m_p_sda,
		i2m_p_end
	} i2m_state_t;

	// what a run of bit slots carries
	typedef enum logic [1:0] {
		i2m_bk_tx,
		i2m_bk_rx,
		i2m_bk_ack
	} i2m_kind_t;

	// both bus lines as sampled
	typedef struct packed {
		logic scl;
		logic sda;
	} i2m_lines_t;

endpackage : i2m_pkg

// >>> core/i2m_rate_gen.sv
/*
 * Clock-rate generator: loads a reload value, counts down once per step
 * enable, pulses timeout one step after reaching zero and halts there.
 * Assumes tick is a one-cycle enable; halt forces the counter idle.
 */
`timescale 1ns/1ps
module i2m_rate_gen #(
	parameter int W = 7
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic         halt,
	input  wire logic [W-1:0] reload,
	output logic              timeout
);
	logic [W-1:0] count;
	logic         active;

	// a period spans reload+1 steps; halt drops a stale count after an abort
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count   <= '0;
			active  <= 1'b0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (load) begin
				count  <= reload;
				active <= 1'b1;
			end else if (halt) begin
				active <= 1'b0;
			end else if (tick && active) begin
				if (count == '0) begin
					active  <= 1'b0;
					timeout <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule : i2m_rate_gen

// >>> core/i2m_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous levels; reset value is the idle-high bus.
 */
`timescale 1ns/1ps
module i2m_sync #(
	parameter int W = 2
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// first flop feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : i2m_sync

// >>> tb/i2m_props.sv
/* port assertions of the i2c master port.
   assumes bind onto i2m_master, one clock mclk, reset rst */
`timescale 1ns/1ps
module i2m_props (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// data pulled low while the clock is released: a start edge
	sequence start_edge;
		$rose(sda_oe) && !scl_oe;
	endsequence
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// bus handshake and read data shape
	a_ack_one_pulse: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h05 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	// pads only ever pull low
	a_pads_open_drain: assert property (!scl_o && !sda_o) else $error("pad drives high");
	// line timing of start, hold and generator periods
	a_start_lines_hi: assert property (start_edge |-> $past(scl_i, 3)) else $error("start with clock low");
	a_start_sda_hold: assert property (start_edge |=> sda_oe [*2]) else $error("start hold too short");
	a_scl_low_min: assert property ($rose(scl_oe) |=> scl_oe [*2]) else $error("clock low too short");
	a_scl_high_min: assert property ($fell(scl_oe) |=> !scl_oe [*3]) else $error("clock high too short");
endmodule : i2m_props

bind i2m_master i2m_props u_props (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe));

// >>> tb/i2m_slave_model.sv
/* behavioural i2c slave: records each byte, acks or not, may stretch clock.
   assumes resolved open-drain lines with pull-ups in the bench */
`timescale 1ns/1ps
module i2m_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack,
	input  wire logic       stretch,
	output logic            sda_pull,
	output logic            scl_pull,
	output logic [7:0]      last_byte
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	initial begin
		sda_pull = 1'b0;
		scl_pull = 1'b0;
		last_byte = 8'h00;
	end
	// data falling with clock high restarts the bit count
	always @(negedge sda) if (scl) cnt = 4'h0;
	// msb first, eight bits a byte
	always @(posedge scl) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		cnt = cnt + 4'h1;
		if (cnt == 4'h8) last_byte = sh;
	end
	// ack slot is the ninth clock; stretching holds the master off
	always @(negedge scl) begin
		sda_pull = (cnt == 4'h8) && !nack;
		if (cnt == 4'h9) cnt = 4'h0;
		if (stretch) begin
			scl_pull = 1'b1;
			#400 scl_pull = 1'b0;
		end
	end
endmodule : i2m_slave_model

// >>> tb/tb_top.sv
/* self-checking bench of the i2c master port: wishbone tasks, slave model.
   assumes the checker is bound by its own file */
`timescale 1ns/1ps
`include "i2m_consts.svh"
module tb_top;
	logic        mclk, rst, cyc, stb, we, nack, stretch, tb_scl_pull, tb_sda_pull;
	logic [7:0]  adr, b;
	logic [31:0] wdat, q, seed;
	wire  logic [31:0] dat_o;
	wire  logic        ack, scl_o, scl_oe, sda_o, sda_oe, s_sda, s_scl;
	wire  logic [7:0]  slv_byte;
	int          errors, cmp_count;
	// open-drain lines with pull-ups
	wire  logic  scl_w = ~(scl_oe | s_scl | tb_scl_pull);
	wire  logic  sda_w = ~(sda_oe | s_sda | tb_sda_pull);

	i2m_master DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
	i2m_slave_model u_slave (.scl(scl_w), .sda(sda_w), .nack(nack), .stretch(stretch), .sda_pull(s_sda),
		.scl_pull(s_scl), .last_byte(slv_byte));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one classic cycle; waits for ack, bounded by the bench
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		if (n >= 20) chk(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask : wb

	// polling keeps the wait bounded in reads rather than cycles
	task wait_flag(input int bitn);
		int n;
		n = 0;
		do begin
			wb(1'b0, `I2M_OFS_FLAGS, 8'h00);
			n++;
		end while (q[bitn] !== 1'b1 && n < 400);
		chk(32'(q[bitn]), 32'h1);
	endtask : wait_flag

	task clr;
		wb(1'b1, `I2M_OFS_FLAGS, 8'h03);
		wb(1'b1, `I2M_OFS_CTRL, 8'h28);
		wb(1'b0, `I2M_OFS_FLAGS, 8'h00);
		chk(q, 32'h0);
	endtask : clr

	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// watchdog well beyond the expected run
	initial begin
		#3000000;
		chk(32'h0, 32'h1);
		end_of_test;
	end

	initial begin
		{cyc, stb, we, nack, stretch, tb_scl_pull, tb_sda_pull} = 7'h00;
		{adr, wdat, errors, cmp_count} = '0;
		seed = 32'h20;
		rst = 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values, unmapped offset included
		for (int o = 0; o <= 8'h18; o += 4) begin
			wb(1'b0, 8'(o), 8'h00);
			chk(q, 32'h0);
		end
		wb(1'b1, `I2M_OFS_RELOAD, 8'hff);
		wb(1'b0, `I2M_OFS_RELOAD, 8'h00);
		chk(q, 32'h7f);
		seed = xs(seed);
		wb(1'b1, `I2M_OFS_RELOAD, {6'h0, seed[1:0]});
		wb(1'b1, `I2M_OFS_CTRL, 8'h28);
		// software checks the bus is idle before claiming it
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[4:3]), 32'h0);
		// start, with buffer and control writes behind it refused while busy
		wb(1'b1, `I2M_OFS_CTRL2, 8'h01);
		wb(1'b1, `I2M_OFS_BUF, 8'ha5);
		wb(1'b1, `I2M_OFS_CTRL2, 8'h05);
		wb(1'b0, `I2M_OFS_CTRL, 8'h00);
		chk(32'(q[7]), 32'h1);
		wait_flag(0);
		wb(1'b0, `I2M_OFS_CTRL2, 8'h00);
		chk(32'(q[4:0]), 32'h0);
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[3]), 32'h1);
		chk(32'({scl_w, sda_w}), 32'h2);
		clr;
		// address then data bytes, one stretched, last refused
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			b = (i == 0) ? {seed[7:1], 1'b0} : seed[7:0];
			nack = (i == 3);
			stretch = (i == 2);
			wb(1'b1, `I2M_OFS_BUF, b);
			if (i == 1) begin
				wb(1'b1, `I2M_OFS_BUF, ~b);
				wb(1'b0, `I2M_OFS_CTRL, 8'h00);
				chk(32'(q[7]), 32'h1);
			end
			wait_flag(0);
			chk(32'(slv_byte), 32'(b));
			wb(1'b0, `I2M_OFS_CTRL2, 8'h00);
			chk(32'(q[6]), 32'(nack));
			clr;
		end
		{nack, stretch} = 2'b00;
		// repeated start, buffer write refused meanwhile
		wb(1'b1, `I2M_OFS_CTRL2, 8'h02);
		wb(1'b1, `I2M_OFS_BUF, 8'h11);
		wb(1'b0, `I2M_OFS_CTRL, 8'h00);
		chk(32'(q[7]), 32'h1);
		wait_flag(0);
		wb(1'b0, `I2M_OFS_CTRL2, 8'h00);
		chk(32'(q[1]), 32'h0);
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[3]), 32'h1);
		chk(32'({scl_w, sda_w}), 32'h2);
		clr;
		seed = xs(seed);
		b = {seed[7:1], 1'b1};
		wb(1'b1, `I2M_OFS_BUF, b);
		wait_flag(0);
		chk(32'(slv_byte), 32'(b));
		clr;
		// receive from a released data line, so the byte reads all ones
		wb(1'b1, `I2M_OFS_CTRL2, 8'h08);
		wait_flag(0);
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[0]), 32'h1);
		wb(1'b0, `I2M_OFS_BUF, 8'h00);
		chk(q, 32'hff);
		clr;
		// acknowledge the received byte; data is left pulled low
		wb(1'b1, `I2M_OFS_CTRL2, 8'h10);
		wait_flag(0);
		wb(1'b0, `I2M_OFS_CTRL2, 8'h00);
		chk(32'(q[4:3]), 32'h0);
		chk(32'(sda_oe), 32'h1);
		clr;
		// stop releases both lines and reports bus free
		wb(1'b1, `I2M_OFS_CTRL2, 8'h04);
		wait_flag(0);
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[4]), 32'h1);
		chk(32'({scl_w, sda_w}), 32'h3);
		clr;
		// both lines held low by another party
		tb_scl_pull <= 1'b1;
		tb_sda_pull <= 1'b1;
		repeat (4) @(posedge mclk);
		wb(1'b1, `I2M_OFS_CTRL2, 8'h01);
		wait_flag(1);
		wb(1'b0, `I2M_OFS_CTRL2, 8'h00);
		chk(32'(q[0]), 32'h0);
		chk(32'({scl_oe, sda_oe}), 32'h0);
		tb_scl_pull <= 1'b0;
		tb_sda_pull <= 1'b0;
		clr;
		// disabling clears the seen bits
		wb(1'b1, `I2M_OFS_CTRL, 8'h00);
		wb(1'b0, `I2M_OFS_STAT, 8'h00);
		chk(32'(q[4:3]), 32'h0);
		end_of_test;
	end
endmodule : tb_top
